// ===== dv/ext_access_model.sv
`timescale 1ns/1ps
`default_nettype none

// Stands in for the core side that presents accesses to the external bus.
module ext_access_model (
	input  wire logic        core_clk,
	output logic             acc_req,
	output logic             acc_onchip,
	output logic [23:0]      acc_addr
);
	initial
	begin
		acc_req = 1'b0;
		acc_onchip = 1'b0;
		acc_addr = 24'h000000;
	end

	// One-cycle request; released lines show the inverse so stale values never pass.
	task automatic present(input logic oc, input logic [23:0] a);
		@(posedge core_clk);
		acc_req <= 1'b1;
		acc_onchip <= oc;
		acc_addr <= a;
		@(posedge core_clk);
		acc_req <= 1'b0;
		acc_onchip <= ~oc;
		acc_addr <= ~a;
		#1;
	endtask
endmodule

`default_nettype wire

// ===== dv/ext_bus_area_config_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

module ext_bus_area_config_regs_tb;
	logic        core_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, hw_standby = 1'b0;
	logic        ce = 1'b1;
	logic [3:0]  pstrb = 4'hf;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [2:0]  op_mode = 3'h1, acc_area, upper_addr_pin_sel;
	logic        acc_req, acc_onchip, acc_valid, acc_three_state, acc_wait_pin_honour, err;
	logic [23:0] acc_addr;
	logic [1:0]  acc_wait_count;
	ext_bus_cfg_pkg::wait_mode_e acc_wait_mode;
	int          err_count = 0;
	int          num_checks = 0;
	logic [7:0]  rst_val [4] = '{8'hff, 8'hf3, 8'hff, 8'hfe};
	logic [2:0]  wm_exp [4] = '{3'h3, 3'h0, 3'h2, 3'h6};

	always #5 core_clk = ~core_clk;

	ext_access_model i_ext_access_model (.core_clk(core_clk), .acc_req(acc_req),
		.acc_onchip(acc_onchip), .acc_addr(acc_addr));

	ext_bus_area_config_regs i_ext_bus_area_config_regs (.core_clk(core_clk), .resetn(resetn),
		.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.op_mode(op_mode), .hw_standby(hw_standby), .acc_req(acc_req),
		.acc_onchip(acc_onchip), .acc_addr(acc_addr), .acc_valid(acc_valid),
		.acc_area(acc_area), .acc_three_state(acc_three_state), .acc_wait_mode(acc_wait_mode),
		.acc_wait_count(acc_wait_count), .acc_wait_pin_honour(acc_wait_pin_honour),
		.upper_addr_pin_sel(upper_addr_pin_sel));

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask

	// The request stands until the rising edge at which pready is seen high; the answer is
	// taken at that edge and only then is the request released.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("access cycles", 32'h1, 32'(n));
	endtask

	task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
		apb(1'b0, a, 32'h0);
		chk("register", {24'h0, exp}, rd);
	endtask

	task automatic all_reset_values();
		for (int i = 0; i < 4; i++)
			rchk(12'(4 * i), rst_val[i]);
	endtask

	// Packs every access attribute so one comparison covers the whole answer.
	task automatic achk(input logic oc, input logic [23:0] a, input logic [10:0] exp);
		i_ext_access_model.present(oc, a);
		chk("access", 32'(exp), 32'({acc_valid, acc_area, acc_three_state, acc_wait_mode,
			acc_wait_count, acc_wait_pin_honour}));
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial
	begin
		#100000;
		err_count++;
		tally_and_finish();
	end

	initial
	begin
		repeat (5) @(posedge core_clk);
		resetn <= 1'b1;
		all_reset_values();
		apb(1'b1, 12'h004, 32'h00);
		rchk(12'h004, 8'hf0);
		apb(1'b1, 12'h00c, 32'h00);
		rchk(12'h00c, 8'hfe);
		apb(1'b1, 12'h00c, 32'h01);
		rchk(12'h00c, 8'hff);
		chk("pin select", 32'h0, 32'(upper_addr_pin_sel));
		apb(1'b1, 12'h010, 32'h55);
		chk("slave error", 32'h1, 32'(err));
		apb(1'b1, 12'h000, 32'h0f);
		apb(1'b1, 12'h008, 32'hfd);
		pstrb <= 4'h0;
		apb(1'b1, 12'h000, 32'h00);
		pstrb <= 4'hf;
		rchk(12'h000, 8'h0f);
		for (int m = 0; m < 4; m++)
		begin
			apb(1'b1, 12'h004, 32'(m * 4 + 2));
			achk(1'b0, 24'h00000, {4'h8, 1'b1, wm_exp[m], (m == 1) ? 2'h0 : 2'h2, m[1]});
		end
		achk(1'b0, 24'h20000, {4'h9, 1'b1, 3'h1, 2'h0, 1'b1});
		achk(1'b0, 24'h80000, {4'hc, 1'b0, 3'h0, 2'h0, 1'b0});
		i_ext_access_model.present(1'b1, 24'h00000);
		chk("on-chip three state", 32'h0, 32'(acc_three_state));
		@(posedge core_clk);
		op_mode <= 3'h7;
		i_ext_access_model.present(1'b0, 24'h00000);
		chk("single chip three state", 32'h0, 32'(acc_three_state));
		@(posedge core_clk);
		op_mode <= 3'h3;
		achk(1'b0, 24'h400000, {4'ha, 1'b1, 3'h6, 2'h2, 1'b1});
		apb(1'b1, 12'h00c, 32'h9e);
		rchk(12'h00c, 8'h9e);
		chk("pin select", 32'h3, 32'(upper_addr_pin_sel));
		// A reload request while the clock enable is low must leave the address control register at 9e hex.
		@(posedge core_clk);
		ce <= 1'b0;
		hw_standby <= 1'b1;
		repeat (2) @(posedge core_clk);
		ce <= 1'b1;
		hw_standby <= 1'b0;
		rchk(12'h00c, 8'h9e);
		@(posedge core_clk);
		hw_standby <= 1'b1;
		@(posedge core_clk);
		hw_standby <= 1'b0;
		all_reset_values();
		tally_and_finish();
	end
endmodule

`default_nettype wire

// ===== src/ext_bus_area_config_regs.sv
// Summary of operation
// (R1) Area bit clear two-state, set three-state.
// (R2) Access-state register resets to all ones.
// (R3) On-chip accesses take fixed state count.
// (R4) Single-chip mode ignores state and wait bits.
// (R5) Wait control register resets to f3 hex.
// (R6) Upper wait control nibble reads one, unwritable.
// (R7) Wait mode field selects one of four modes.
// (R8) Wait count inserts zero to three states.
// (R9) Cleared wait enable selects pin wait mode 0.
// (R10) Wait enable register resets to all ones.
// (R11) Address control register resets to fe hex.
// (R12) Cleared enable bit gives pin upper address.
// (R13) Upper enables locked outside large-address modes.
// (R14) Bits 4-1 read one; bit 0 writable.
// (R15) Wait pin honoured only in three-state areas.
// (R16) Eight equal areas split the external space.
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module ext_bus_area_config_regs #(
	parameter int ADDR_W = 12
) (
	input  wire logic                      core_clk,
	input  wire logic                      resetn,
	input  wire logic                      ce,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [ADDR_W-1:0]         paddr,
	input  wire logic [31:0]               pwdata,
	input  wire logic [3:0]                pstrb,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic [2:0]                op_mode,
	input  wire logic                      hw_standby,
	input  wire logic                      acc_req,
	input  wire logic                      acc_onchip,
	input  wire logic [23:0]               acc_addr,
	output logic                           acc_valid,
	output logic      [2:0]                acc_area,
	output logic                           acc_three_state,
	output ext_bus_cfg_pkg::wait_mode_e    acc_wait_mode,
	output logic      [1:0]                acc_wait_count,
	output logic                           acc_wait_pin_honour,
	output logic      [2:0]                upper_addr_pin_sel
);

	// The decoder only looks at the low twelve address bits.
	// A wider bus would alias the registers, so such widths are refused when elaborated.
	if (ADDR_W < 4 || ADDR_W > 12)
	begin : g_addr_w_check
		$error("ADDR_W must lie between 4 and 12");
	end

	logic [7:0]  area_three_state_sel_q, area_three_state_sel_d;
	logic [7:0]  wait_mode_and_count_q,  wait_mode_and_count_d;
	logic [7:0]  area_wait_ctrl_en_q,    area_wait_ctrl_en_d;
	logic [7:0]  upper_addr_ctrl_q,      upper_addr_ctrl_d;
	logic [31:0] prdata_q, prdata_d;
	logic        pready_q, pready_d;
	logic        pslverr_q, pslverr_d;
	logic [11:0] reg_addr;
	logic        hit_ast, hit_wcr, hit_wce, hit_adr, hit_any;
	logic        large_mode, wr_en;
	logic [7:0]  rd_byte;

	// Address decode shared by reads and writes.
	always_comb
	begin
		reg_addr   = 12'(paddr) & 12'hffc;
		hit_ast    = reg_addr == ext_bus_cfg_pkg::OFF_AREA_ACCESS_STATE_SELECT;
		hit_wcr    = reg_addr == ext_bus_cfg_pkg::OFF_WAIT_MODE_AND_COUNT;
		hit_wce    = reg_addr == ext_bus_cfg_pkg::OFF_AREA_WAIT_CONTROL_ENABLE;
		hit_adr    = reg_addr == ext_bus_cfg_pkg::OFF_UPPER_ADDRESS_PIN_CTRL;
		hit_any    = hit_ast | hit_wcr | hit_wce | hit_adr;
		large_mode = (op_mode == ext_bus_cfg_pkg::MODE_LARGE_A) ||
			(op_mode == ext_bus_cfg_pkg::MODE_LARGE_B);
		// Writes land only on the completing edge, so a held request never writes twice.
		wr_en      = psel & penable & pready_q & pwrite & pstrb[0] & hit_any;
	end

	// Register next values; hardware standby acts as a synchronous reload.
	always_comb
	begin
		area_three_state_sel_d = area_three_state_sel_q;
		wait_mode_and_count_d  = wait_mode_and_count_q;
		area_wait_ctrl_en_d    = area_wait_ctrl_en_q;
		upper_addr_ctrl_d      = upper_addr_ctrl_q;
		if (hw_standby)
		begin
			area_three_state_sel_d = ext_bus_cfg_pkg::RST_AREA_ACCESS_STATE; // [R2]
			wait_mode_and_count_d  = ext_bus_cfg_pkg::RST_WAIT_MODE_COUNT; // [R5]
			area_wait_ctrl_en_d    = ext_bus_cfg_pkg::RST_AREA_WAIT_CTRL_EN; // [R10]
			upper_addr_ctrl_d      = ext_bus_cfg_pkg::RST_UPPER_ADDR_PIN; // [R11]
		end
		else if (wr_en)
		begin
			if (hit_ast)
				area_three_state_sel_d = pwdata[7:0];
			if (hit_wcr)
				wait_mode_and_count_d = {ext_bus_cfg_pkg::ONES_NIBBLE, pwdata[3:0]}; // [R6]
			if (hit_wce)
				area_wait_ctrl_en_d = pwdata[7:0];
			if (hit_adr)
			begin
				upper_addr_ctrl_d[7:5] = large_mode ? pwdata[7:5] : upper_addr_ctrl_q[7:5]; // [R13]
				upper_addr_ctrl_d[4:1] = ext_bus_cfg_pkg::ONES_NIBBLE; // [R14]
				upper_addr_ctrl_d[0]   = pwdata[0]; // [R14]
			end
		end
	end

	// Software standby is simply the absence of writes: the contents stay put.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			area_three_state_sel_q <= ext_bus_cfg_pkg::RST_AREA_ACCESS_STATE; // [R2]
			wait_mode_and_count_q  <= ext_bus_cfg_pkg::RST_WAIT_MODE_COUNT; // [R5]
			area_wait_ctrl_en_q    <= ext_bus_cfg_pkg::RST_AREA_WAIT_CTRL_EN; // [R10]
			upper_addr_ctrl_q      <= ext_bus_cfg_pkg::RST_UPPER_ADDR_PIN; // [R11]
		end
		else if (ce)
		begin
			area_three_state_sel_q <= area_three_state_sel_d;
			wait_mode_and_count_q  <= wait_mode_and_count_d;
			area_wait_ctrl_en_q    <= area_wait_ctrl_en_d;
			upper_addr_ctrl_q      <= upper_addr_ctrl_d;
		end
	end

	// The answer is prepared in the setup cycle so that every bus output leaves a flop.
	always_comb
	begin
		case (1'b1)
			hit_ast: rd_byte = area_three_state_sel_q;
			hit_wcr: rd_byte = wait_mode_and_count_q; // [R6]
			hit_wce: rd_byte = area_wait_ctrl_en_q;
			hit_adr: rd_byte = upper_addr_ctrl_q;
			default: rd_byte = 8'h00;
		endcase
		pready_d  = psel & ~penable;
		pslverr_d = psel & ~penable & ~hit_any;
		prdata_d  = (psel & ~penable & ~pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
	end

	// Bus answer flops.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			prdata_q  <= 32'h00000000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else if (ce)
		begin
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	logic                       acc_valid_q, acc_valid_d;
	logic [2:0]                 acc_area_q, acc_area_d;
	logic                       acc_ts_q, acc_ts_d;
	ext_bus_cfg_pkg::wait_mode_e acc_mode_q, acc_mode_d;
	logic [1:0]                 acc_count_q, acc_count_d;
	logic                       acc_honour_q, acc_honour_d;
	logic [2:0]                 pin_sel_q, pin_sel_d;
	logic                       ext_acc, area_ts, area_wce;

	// Per-access attributes from the area of the presented address.
	always_comb
	begin
		if (large_mode)
			acc_area_d = acc_addr[ext_bus_cfg_pkg::AREA_LARGE_LSB +: 3]; // [R16]
		else
			acc_area_d = acc_addr[ext_bus_cfg_pkg::AREA_SMALL_LSB +: 3]; // [R16]
		// Single-chip mode has no external space, so the area bits never apply.
		ext_acc  = acc_req & ~acc_onchip & (op_mode != ext_bus_cfg_pkg::MODE_SINGLE); // [R3] [R4]
		area_ts  = area_three_state_sel_q[acc_area_d];
		area_wce = area_wait_ctrl_en_q[acc_area_d];
		acc_valid_d = acc_req;
		acc_ts_d    = ext_acc & area_ts; // [R1]
		acc_mode_d  = ext_bus_cfg_pkg::WM_DISABLED;
		if (acc_ts_d && !area_wce)
			acc_mode_d = ext_bus_cfg_pkg::WM_PIN0; // [R9]
		else if (acc_ts_d)
		begin
			case (wait_mode_and_count_q[ext_bus_cfg_pkg::WAIT_MODE_SEL_LSB +: 2]) // [R7]
				ext_bus_cfg_pkg::WMS_PROG: acc_mode_d = ext_bus_cfg_pkg::WM_PROG;
				ext_bus_cfg_pkg::WMS_PIN1: acc_mode_d = ext_bus_cfg_pkg::WM_PIN1;
				ext_bus_cfg_pkg::WMS_AUTO: acc_mode_d = ext_bus_cfg_pkg::WM_AUTO;
				default:                   acc_mode_d = ext_bus_cfg_pkg::WM_DISABLED;
			endcase
		end
		// Controller-inserted states apply only to modes in which the controller counts.
		if (acc_mode_d == ext_bus_cfg_pkg::WM_PROG || acc_mode_d == ext_bus_cfg_pkg::WM_PIN1 ||
			acc_mode_d == ext_bus_cfg_pkg::WM_AUTO)
			acc_count_d = wait_mode_and_count_q[ext_bus_cfg_pkg::WAIT_COUNT_LSB +: 2]; // [R8]
		else
			acc_count_d = 2'h0;
		acc_honour_d = acc_ts_d && (acc_mode_d != ext_bus_cfg_pkg::WM_PROG) &&
			(acc_mode_d != ext_bus_cfg_pkg::WM_DISABLED); // [R15]
	end

	// Each upper address pin is handed over only while its enable is clear.
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_pin
			always_comb
			begin
				pin_sel_d[gi] = large_mode & ~upper_addr_ctrl_q[ext_bus_cfg_pkg::ADDR_OUT_EN_LSB + gi]; // [R12] [R13]
			end
		end
	endgenerate

	// Attribute and pin flops.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			acc_valid_q  <= 1'b0;
			acc_area_q   <= 3'h0;
			acc_ts_q     <= 1'b0;
			acc_mode_q   <= ext_bus_cfg_pkg::WM_DISABLED;
			acc_count_q  <= 2'h0;
			acc_honour_q <= 1'b0;
			pin_sel_q    <= 3'h0;
		end
		else if (ce)
		begin
			acc_valid_q  <= acc_valid_d;
			acc_area_q   <= acc_area_d;
			acc_ts_q     <= acc_ts_d;
			acc_mode_q   <= acc_mode_d;
			acc_count_q  <= acc_count_d;
			acc_honour_q <= acc_honour_d;
			pin_sel_q    <= pin_sel_d;
		end
	end

	assign acc_valid           = acc_valid_q;
	assign acc_area            = acc_area_q;
	assign acc_three_state     = acc_ts_q;
	assign acc_wait_mode       = acc_mode_q;
	assign acc_wait_count      = acc_count_q;
	assign acc_wait_pin_honour = acc_honour_q;
	assign upper_addr_pin_sel  = pin_sel_q;

	// Checks on the register file and the access attributes.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	AST_AREA_ACCESS_STATE_SELECT_RELOAD: assert property (ce && hw_standby |=> area_three_state_sel_q == 8'hff) // [R2]
		else $error("access-state register not reloaded");
	AST_WCR_RELOAD: assert property (ce && hw_standby |=> wait_mode_and_count_q == 8'hf3) // [R5]
		else $error("wait control register not reloaded");
	AST_AREA_WAIT_CONTROL_ENABLE_RELOAD: assert property (ce && hw_standby |=> area_wait_ctrl_en_q == 8'hff) // [R10]
		else $error("wait enable register not reloaded");
	AST_UPPER_ADDRESS_PIN_CONTROL_RELOAD: assert property (ce && hw_standby |=> upper_addr_ctrl_q == 8'hfe) // [R11]
		else $error("address control register not reloaded");
	AST_WCR_UPPER_READ: assert property (pready_q && psel && !pwrite && hit_wcr |-> prdata_q[7:4] == 4'hf) // [R6]
		else $error("wait control upper bits not read as one");
	AST_AREA_STATE: assert property (ce && ext_acc |=> acc_three_state == $past(area_ts)) // [R1]
		else $error("access state does not follow area bit");
	AST_ONCHIP_FIXED: assert property (ce && acc_req && acc_onchip |=> !acc_three_state && acc_wait_count == 2'h0) // [R3]
		else $error("on-chip access picked up area settings");
	AST_SINGLE_CHIP: assert property (ce && acc_req && op_mode == 3'h7 |=> !acc_three_state && !acc_wait_pin_honour) // [R4]
		else $error("single-chip access used area settings");
	AST_PROG_COUNT: assert property (ce && acc_ts_d && area_wce && wait_mode_and_count_q[3:2] == 2'h0
		|=> acc_wait_mode == ext_bus_cfg_pkg::WM_PROG && acc_wait_count == $past(wait_mode_and_count_q[1:0])) // [R7] [R8]
		else $error("programmable wait count wrong");
	AST_PIN0_MODE: assert property (ce && acc_ts_d && !area_wce |=> acc_wait_mode == ext_bus_cfg_pkg::WM_PIN0) // [R9]
		else $error("disabled controller did not give pin wait mode 0");
	AST_PIN_SELECT: assert property (ce ##1 ce |-> upper_addr_pin_sel == ($past(large_mode) ? ~$past(upper_addr_ctrl_q[7:5]) : 3'h0)) // [R12]
		else $error("upper address pin selection wrong");
	AST_UPPER_LOCK: assert property (ce && wr_en && hit_adr && !large_mode && !hw_standby
		|=> upper_addr_ctrl_q[7:5] == $past(upper_addr_ctrl_q[7:5])) // [R13]
		else $error("upper enables written outside large modes");
	AST_UPPER_ADDRESS_PIN_CONTROL_LOW: assert property (ce && wr_en && hit_adr && !hw_standby
		|=> upper_addr_ctrl_q[4:1] == 4'hf && upper_addr_ctrl_q[0] == $past(pwdata[0])) // [R14]
		else $error("address control low bits wrong");
	AST_HONOUR_TS: assert property (acc_wait_pin_honour |-> acc_three_state) // [R15]
		else $error("wait pin honoured in two-state area");
	AST_AREA_LARGE: assert property (ce && acc_req && large_mode |=> acc_area == $past(acc_addr[23:21])) // [R16]
		else $error("large-mode area index wrong");

	COV_WRITE_WCR: cover property (wr_en && hit_wcr);
	COV_PIN_AUTO: cover property (acc_wait_mode == ext_bus_cfg_pkg::WM_AUTO && acc_wait_pin_honour);
	COV_PIN_HANDOVER: cover property (upper_addr_pin_sel == 3'h7);
	COV_BAD_ADDR: cover property (pready_q && pslverr_q);

endmodule

`default_nettype wire

// ===== src/ext_bus_cfg_pkg.sv
// Shared constants for the external bus area configuration registers.
package ext_bus_cfg_pkg;

	// Register byte offsets on the APB slave.
	localparam logic [11:0] OFF_AREA_ACCESS_STATE_SELECT = 12'h000;
	localparam logic [11:0] OFF_WAIT_MODE_AND_COUNT      = 12'h004;
	localparam logic [11:0] OFF_AREA_WAIT_CONTROL_ENABLE = 12'h008;
	localparam logic [11:0] OFF_UPPER_ADDRESS_PIN_CTRL   = 12'h00c;

	// Values after reset and after hardware standby.
	localparam logic [7:0] RST_AREA_ACCESS_STATE = 8'hff;
	localparam logic [7:0] RST_WAIT_MODE_COUNT   = 8'hf3;
	localparam logic [7:0] RST_AREA_WAIT_CTRL_EN = 8'hff;
	localparam logic [7:0] RST_UPPER_ADDR_PIN    = 8'hfe;

	// Field positions.
	localparam int WAIT_MODE_SEL_LSB  = 2;
	localparam int WAIT_COUNT_LSB     = 0;
	localparam int ADDR_OUT_EN_LSB    = 5;
	localparam int AREA_SMALL_LSB     = 17;
	localparam int AREA_LARGE_LSB     = 21;
	localparam logic [3:0] ONES_NIBBLE = 4'hf;

	// Operating modes that matter here.
	localparam logic [2:0] MODE_LARGE_A  = 3'h3;
	localparam logic [2:0] MODE_LARGE_B  = 3'h6;
	localparam logic [2:0] MODE_SINGLE   = 3'h7;

	// Wait mode select encodings.
	localparam logic [1:0] WMS_PROG  = 2'h0;
	localparam logic [1:0] WMS_NONE  = 2'h1;
	localparam logic [1:0] WMS_PIN1  = 2'h2;
	localparam logic [1:0] WMS_AUTO  = 2'h3;

	// Effective wait behaviour of one external access.
	typedef enum logic [2:0] {
		WM_DISABLED = 3'h0,
		WM_PIN0     = 3'h1,
		WM_PROG     = 3'h3,
		WM_PIN1     = 3'h2,
		WM_AUTO     = 3'h6
	} wait_mode_e;

endpackage
